/* design/fpo_pkg.sv */
package fpo_pkg;

  // ----------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------
  localparam logic [11:0] CFG_OFFSET       = 12'h404;
  localparam logic [31:0] CFG_RESET        = 32'h0000_0001;
  localparam int          CFG_EXT_SEQ_BIT  = 0;
  localparam int          CFG_PANEL_ON_BIT = 1;
  localparam int          CFG_HS_POL_BIT   = 22;
  localparam int          CFG_VS_POL_BIT   = 23;
  localparam int          CFG_FRAME_SEL_BIT = 24;
  localparam int          CFG_DE_EN_BIT    = 25;
  localparam int          CFG_LINE_SEL_BIT = 26;
  localparam int          CFG_STAT_SUPPLY_BIT = 31;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SEQ_STEP_NS     = 1000;
  localparam int PIX_PERIOD_PS   = 15000;
  localparam int SEQ_STEP_CYC    = (SEQ_STEP_NS * 1000) / PIX_PERIOD_PS;
  localparam int DATA_W          = 12;
  localparam int BUF_DEPTH       = 2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] upper;
    logic [DATA_W-1:0] lower;
    logic              de;
    logic              hs;
    logic              vs;
  } fpo_pix_t;

  typedef enum logic [1:0] {SEQ_OFF, SEQ_VDD, SEQ_CON, SEQ_ON} fpo_seq_t;

endpackage

/* design/fpo_top.sv */
`timescale 1ns/1ps
// Contract
// - Drive a panel shift clock whose rising edge latches each data word.
// - Present pixel data on upper and lower 12-bit scan buses.
// - Config bit 25 set enables display-enable marking active pixel cycles.
// - Config bit 26 selects line output: latch pulse (0) or horizontal sync (1).
// - Horizontal sync mode reproduces input sync with the pixel pipeline delay.
// - Config bit 22 sets horizontal sync polarity: 0 high, 1 low.
// - Config bit 24 selects frame output: frame pulse (0) or vertical sync (1).
// - Vertical sync mode reproduces input sync with the pixel pipeline delay.
// - Config bit 23 sets vertical sync polarity: 0 high, 1 low.
// - Backlight-off output low switches backlight off, high otherwise.
// - Panel supply enable high applies panel supply, low removes it.
// - Contrast enable high applies bias voltage, low removes it.
// - External sequencing: supply enable follows request; internal: request ignored.
// - External sequencing: contrast enable follows request; internal: request ignored.
// - Dot clock runs always after reset; it clocks input capture and panel logic.
module fpo_top
  import fpo_pkg::*;
#(
  parameter int P_SEQ_STEP_CYC = SEQ_STEP_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_cfg_we,
  input  wire logic [31:0]       i_cfg_wdata,
  output logic      [31:0]       o_cfg_rdata,
  input  wire logic              i_pixel_clock_in,
  input  wire fpo_pix_t          i_pixel,
  input  wire logic              i_pixel_valid,
  output logic                   o_pixel_ready,
  input  wire logic              i_panel_ready,
  input  wire logic              i_supply_request_in,
  input  wire logic              i_contrast_request_in,
  output logic                   o_panel_shift_clock,
  output logic      [DATA_W-1:0] o_upper_scan_data,
  output logic      [DATA_W-1:0] o_lower_scan_data,
  output logic                   o_tft_display_enable,
  output logic                   o_line_latch_pulse,
  output logic                   o_first_line_marker,
  output logic                   o_backlight_off_n,
  output logic                   o_panel_supply_enable,
  output logic                   o_panel_contrast_enable
);

  initial begin
    if (P_SEQ_STEP_CYC < 1 || P_SEQ_STEP_CYC > 65535) begin
      $error("P_SEQ_STEP_CYC out of range.");
    end
  end

  // ----------------------------------------------------------------------
  // Configuration register on the system clock
  // ----------------------------------------------------------------------
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [31:0] rdata_d;
  logic [1:0]  stat_sync_q;

  always_comb begin
    cfg_d = i_cfg_we ? i_cfg_wdata : cfg_q;
    rdata_d = cfg_d;
    rdata_d[CFG_STAT_SUPPLY_BIT] = stat_sync_q[1];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_q       <= CFG_RESET;
      o_cfg_rdata <= CFG_RESET;
      stat_sync_q <= 2'h0;
    end else begin
      cfg_q       <= cfg_d;
      o_cfg_rdata <= rdata_d;
      stat_sync_q <= {stat_sync_q[0], o_panel_supply_enable};
    end
  end

  // ----------------------------------------------------------------------
  // Synchronisers into the dot clock domain
  // ----------------------------------------------------------------------
  logic [1:0]  rst_sync_q;
  logic [31:0] cfg_m_q;
  logic [31:0] cfg_s_q;
  logic [1:0]  req_m_q;
  logic [1:0]  req_s_q;
  logic        rdy_m_q;
  logic        rdy_s_q;
  logic        rst_p;

  assign rst_p = rst_sync_q[1];

  always_ff @(posedge i_pixel_clock_in or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_sync_q <= 2'h3;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b0};
    end
  end

  always_ff @(posedge i_pixel_clock_in or posedge rst_p) begin
    if (rst_p) begin
      cfg_m_q <= CFG_RESET;
      cfg_s_q <= CFG_RESET;
      req_m_q <= 2'h0;
      req_s_q <= 2'h0;
      rdy_m_q <= 1'b0;
      rdy_s_q <= 1'b0;
    end else begin
      cfg_m_q <= cfg_q;
      cfg_s_q <= cfg_m_q;
      req_m_q <= {i_contrast_request_in, i_supply_request_in};
      req_s_q <= req_m_q;
      rdy_m_q <= i_panel_ready;
      rdy_s_q <= rdy_m_q;
    end
  end

  // ----------------------------------------------------------------------
  // Two-entry buffer and panel output stage
  // ----------------------------------------------------------------------
  fpo_pix_t   buf_q [BUF_DEPTH];
  fpo_pix_t   buf_d [BUF_DEPTH];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       wr_q;
  logic       wr_d;
  logic       rd_q;
  logic       rd_d;
  logic       phase_q;
  logic       phase_d;
  logic       push;
  logic       pop;
  fpo_pix_t   word_q;
  fpo_pix_t   word_d;
  logic       prev_hs_q;
  logic       prev_vs_q;
  logic       lp_d;
  logic       fp_d;
  logic       line_d;
  logic       frame_d;
  logic       de_d;

  always_comb begin
    push    = i_pixel_valid && o_pixel_ready;
    pop     = !phase_q && (cnt_q != 2'h0) && rdy_s_q;
    buf_d   = buf_q;
    wr_d    = wr_q;
    rd_d    = rd_q;
    word_d  = word_q;
    phase_d = 1'b0;
    lp_d    = 1'b0;
    fp_d    = 1'b0;
    if (push) begin
      buf_d[wr_q] = i_pixel;
      wr_d        = !wr_q;
    end
    if (pop) begin
      word_d  = buf_q[rd_q];
      rd_d    = !rd_q;
      phase_d = 1'b1;
      lp_d    = buf_q[rd_q].hs && !prev_hs_q;
      fp_d    = buf_q[rd_q].vs && !prev_vs_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    line_d = cfg_s_q[CFG_LINE_SEL_BIT] ?
             (word_d.hs ^ cfg_s_q[CFG_HS_POL_BIT]) : lp_d;
    frame_d = cfg_s_q[CFG_FRAME_SEL_BIT] ?
              (word_d.vs ^ cfg_s_q[CFG_VS_POL_BIT]) : fp_d;
    de_d = word_d.de && cfg_s_q[CFG_DE_EN_BIT];
  end

  always_ff @(posedge i_pixel_clock_in or posedge rst_p) begin
    if (rst_p) begin
      buf_q                <= '{default: '0};
      cnt_q                <= 2'h0;
      wr_q                 <= 1'b0;
      rd_q                 <= 1'b0;
      phase_q              <= 1'b0;
      word_q               <= '0;
      prev_hs_q            <= 1'b0;
      prev_vs_q            <= 1'b0;
      o_pixel_ready        <= 1'b0;
      o_panel_shift_clock  <= 1'b0;
      o_upper_scan_data    <= '0;
      o_lower_scan_data    <= '0;
      o_tft_display_enable <= 1'b0;
      o_line_latch_pulse   <= 1'b0;
      o_first_line_marker  <= 1'b0;
    end else begin
      buf_q                <= buf_d;
      cnt_q                <= cnt_d;
      wr_q                 <= wr_d;
      rd_q                 <= rd_d;
      phase_q              <= phase_d;
      word_q               <= word_d;
      prev_hs_q            <= word_d.hs;
      prev_vs_q            <= word_d.vs;
      o_pixel_ready        <= (cnt_d != 2'h2);
      o_panel_shift_clock  <= phase_q;
      o_upper_scan_data    <= word_d.upper;
      o_lower_scan_data    <= word_d.lower;
      o_tft_display_enable <= de_d;
      o_line_latch_pulse   <= line_d;
      o_first_line_marker  <= frame_d;
    end
  end

  // ----------------------------------------------------------------------
  // Panel power sequencing
  // ----------------------------------------------------------------------
  fpo_seq_t    seq_q;
  fpo_seq_t    seq_d;
  logic [15:0] tmr_q;
  logic [15:0] tmr_d;
  logic        ext_seq;
  logic        sup_d;
  logic        con_d;
  logic        bl_d;

  assign ext_seq = cfg_s_q[CFG_EXT_SEQ_BIT];

  always_comb begin
    seq_d = seq_q;
    tmr_d = (tmr_q != 16'h0000) ? tmr_q - 16'h0001 : 16'h0000;
    if (tmr_q == 16'h0000) begin
      if (cfg_s_q[CFG_PANEL_ON_BIT]) begin
        unique case (seq_q)
          SEQ_OFF: seq_d = SEQ_VDD;
          SEQ_VDD: seq_d = SEQ_CON;
          SEQ_CON: seq_d = SEQ_ON;
          SEQ_ON:  seq_d = SEQ_ON;
        endcase
      end else begin
        unique case (seq_q)
          SEQ_OFF: seq_d = SEQ_OFF;
          SEQ_VDD: seq_d = SEQ_OFF;
          SEQ_CON: seq_d = SEQ_VDD;
          SEQ_ON:  seq_d = SEQ_CON;
        endcase
      end
      if (seq_d != seq_q) begin
        tmr_d = 16'(P_SEQ_STEP_CYC);
      end
    end
    if (ext_seq) begin
      sup_d = req_s_q[0];
      con_d = req_s_q[1];
      bl_d  = req_s_q[1] && req_s_q[0];
    end else begin
      sup_d = (seq_q != SEQ_OFF);
      con_d = (seq_q == SEQ_CON) || (seq_q == SEQ_ON);
      bl_d  = (seq_q == SEQ_ON);
    end
  end

  always_ff @(posedge i_pixel_clock_in or posedge rst_p) begin
    if (rst_p) begin
      seq_q                   <= SEQ_OFF;
      tmr_q                   <= 16'h0000;
      o_panel_supply_enable   <= 1'b0;
      o_panel_contrast_enable <= 1'b0;
      o_backlight_off_n       <= 1'b0;
    end else begin
      seq_q                   <= seq_d;
      tmr_q                   <= tmr_d;
      o_panel_supply_enable   <= sup_d;
      o_panel_contrast_enable <= con_d;
      o_backlight_off_n       <= bl_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_pixel_clock_in); endclocking
  default disable iff (rst_p);

  de_gate_a: assert property (!cfg_s_q[CFG_DE_EN_BIT] |=> !o_tft_display_enable)
    else $error("Display enable active while disabled.");
  hsync_pol_a: assert property (cfg_s_q[CFG_LINE_SEL_BIT] |=>
    o_line_latch_pulse == (word_q.hs ^ $past(cfg_s_q[CFG_HS_POL_BIT])))
    else $error("Line output does not follow sync and polarity.");
  vsync_pol_a: assert property (cfg_s_q[CFG_FRAME_SEL_BIT] |=>
    o_first_line_marker == (word_q.vs ^ $past(cfg_s_q[CFG_VS_POL_BIT])))
    else $error("Frame output does not follow sync and polarity.");
  shift_edge_a: assert property ($rose(o_panel_shift_clock) |-> $past(pop, 2))
    else $error("Shift clock rose without a new word.");
  data_align_a: assert property (pop |=> o_upper_scan_data == $past(buf_q[rd_q].upper)
    && o_lower_scan_data == $past(buf_q[rd_q].lower) && word_q.de == $past(buf_q[rd_q].de))
    else $error("Data and enable misaligned.");
  latch_single_a: assert property (!cfg_s_q[CFG_LINE_SEL_BIT] && o_line_latch_pulse
    ##1 !cfg_s_q[CFG_LINE_SEL_BIT] |-> !o_line_latch_pulse)
    else $error("Latch pulse longer than one cycle.");
  buf_full_a: assert property (cnt_q == 2'h2 && !pop |=> !o_pixel_ready && cnt_q == 2'h2)
    else $error("Buffer accepted a word while full.");
  supply_ext_a: assert property (ext_seq ##1 ext_seq |->
    o_panel_supply_enable == $past(req_s_q[0]))
    else $error("Supply enable does not follow request.");
  contrast_ext_a: assert property (ext_seq ##1 ext_seq |->
    o_panel_contrast_enable == $past(req_s_q[1]))
    else $error("Contrast enable does not follow request.");
  backlight_a: assert property (!ext_seq && seq_q != SEQ_ON |=> !o_backlight_off_n)
    else $error("Backlight on before sequence completed.");

  full_c: cover property (cnt_q == 2'h2 && !o_pixel_ready);
  tft_c: cover property (cfg_s_q[CFG_LINE_SEL_BIT] && $rose(o_line_latch_pulse));
  seq_c: cover property (!ext_seq && seq_q == SEQ_ON);
  stn_c: cover property (!cfg_s_q[CFG_FRAME_SEL_BIT] && o_first_line_marker);

endmodule

/* test/fpo_panel_model.sv */
`timescale 1ns/1ps
module fpo_panel_model
  import fpo_pkg::*;
(
  input  wire logic              i_pclk,
  input  wire logic              i_stall,
  input  wire logic              i_shift,
  input  wire logic [DATA_W-1:0] i_upper,
  input  wire logic [DATA_W-1:0] i_lower,
  input  wire logic              i_de,
  input  wire logic              i_line,
  input  wire logic              i_frame,
  output logic                   o_ready
);
  fpo_pix_t got[$];
  fpo_pix_t seen_q;
  logic     shift_q;

  always @(negedge i_pclk) begin
    shift_q <= i_shift;
    seen_q  <= '{i_upper, i_lower, i_de, i_line, i_frame};
    if (i_shift && !shift_q) got.push_back(seen_q);
  end

  assign o_ready = !i_stall;
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
  import fpo_pkg::*;
  logic              clk = 0, pclk = 0, rst = 1, we = 0, valid = 0;
  logic              stall = 0, sreq = 0, creq = 0, ph = 0, pv = 0;
  logic [31:0]       wdata = '0, cfg = '0, rdata;
  fpo_pix_t          pix = '0;
  fpo_pix_t          exp_q[$];
  logic              ready, sc, de, line, frame, bl_n, sup, con, prdy;
  logic [DATA_W-1:0] ud, ld;
  int                num_errors = 0;
  int                comparisons = 0;

  always #5 clk = ~clk;
  always #7.5 pclk = ~pclk;

  fpo_top #(.P_SEQ_STEP_CYC(4)) i_dut (
    .i_clk(clk), .i_sys_rst(rst), .i_cfg_we(we), .i_cfg_wdata(wdata),
    .o_cfg_rdata(rdata), .i_pixel_clock_in(pclk), .i_pixel(pix),
    .i_pixel_valid(valid), .o_pixel_ready(ready), .i_panel_ready(prdy),
    .i_supply_request_in(sreq), .i_contrast_request_in(creq),
    .o_panel_shift_clock(sc), .o_upper_scan_data(ud), .o_lower_scan_data(ld),
    .o_tft_display_enable(de), .o_line_latch_pulse(line),
    .o_first_line_marker(frame), .o_backlight_off_n(bl_n),
    .o_panel_supply_enable(sup), .o_panel_contrast_enable(con));

  fpo_panel_model u_panel (
    .i_pclk(pclk), .i_stall(stall), .i_shift(sc), .i_upper(ud), .i_lower(ld),
    .i_de(de), .i_line(line), .i_frame(frame), .o_ready(prdy));

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic dot(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wr(input logic [31:0] v);
    @(posedge clk);
    we    <= 1'h1;
    wdata <= v;
    @(posedge clk);
    we    <= 1'h0;
    cfg = v;
    @(negedge clk);
    chk(rdata & 32'h7FFFFFFF, v);
    dot(6);
  endtask

  task automatic push(input fpo_pix_t w);
    fpo_pix_t e;
    int       n;
    e = w;
    e.de = w.de & cfg[CFG_DE_EN_BIT];
    e.hs = cfg[CFG_LINE_SEL_BIT] ? w.hs ^ cfg[CFG_HS_POL_BIT] : w.hs & !ph;
    e.vs = cfg[CFG_FRAME_SEL_BIT] ? w.vs ^ cfg[CFG_VS_POL_BIT] : w.vs & !pv;
    ph = w.hs;
    pv = w.vs;
    exp_q.push_back(e);
    pix   <= w;
    valid <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ready !== 1'b1 && n < 300);
    chk(32'(ready), 32'h1);
  endtask

  task automatic stream(input int n);
    for (int i = 0; i < n; i++) begin
      push('{12'(i * 37 + 5), 12'(i * 11 + 3), 1'(i % 2), 1'(i % 4 == 1), 1'(i == 2)});
    end
    valid <= 1'h0;
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (u_panel.got.size() < exp_q.size() && n < 500) begin
      dot(1);
      n++;
    end
    chk(32'(u_panel.got.size()), 32'(exp_q.size()));
    foreach (exp_q[k]) begin
      if (k < u_panel.got.size()) begin
        chk(32'(u_panel.got[k]), 32'(exp_q[k]));
      end
    end
    u_panel.got.delete();
    exp_q.delete();
  endtask

  initial begin
    logic [31:0] modes[3] = '{32'h07000001, 32'h07C00001, 32'h00000001};
    repeat (5) @(posedge clk);
    chk(32'({sc, de, line, frame, sup, con, bl_n}), 32'h0);
    rst <= 1'h0;
    chk(rdata, CFG_RESET);
    foreach (modes[m]) begin
      wr(modes[m]);
      stream(8);
      drain();
    end
    stall <= 1'h1;
    fork
      stream(6);
      begin
        dot(40);
        chk(32'(ready), 32'h0);
        stall <= 1'h0;
      end
    join
    drain();
    for (int k = 0; k < 4; k++) begin
      sreq <= k[1];
      creq <= k[0];
      dot(8);
      chk(32'({sup, con, bl_n}), 32'({k[1], k[0], k[1] & k[0]}));
    end
    wr(32'h00000000);
    dot(40);
    chk(32'({sup, con, bl_n}), 32'h0);
    wr(32'h00000002);
    dot(40);
    chk(32'({sup, con, bl_n, rdata[31]}), 32'hF);
    print_verdict();
  end

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule
